// ### audio_dac_clock_power_sequencer.sv
// clock set-up, dac init cycle, volume soft transition and speaker power gating
`timescale 1ns/1ps
module audio_dac_clock_power_sequencer
    import seq_pkg::*;
#(
    parameter int LOCK_MCLK = LOCK_MCLK_CYC,
    parameter int LOCK_FRAME = LOCK_FRAME_CYC,
    parameter int LOCK_BIT = LOCK_BIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control bits from host
    input wire logic ref_voltage_power,
    input wire logic pll_power,
    input wire logic [3:0] pll_ref_sel,
    input wire logic master_sel,
    input wire logic master_clock_out_enable,
    input wire logic dac_power,
    input wire logic alc_enable,
    input wire logic volume_couple,
    input wire logic [7:0] alc_left_volume,
    input wire logic [7:0] alc_right_volume,
    input wire logic [7:0] out_left_volume,
    input wire logic [7:0] out_right_volume,
    input wire logic mono_amp_power,
    input wire logic speaker_amp_power,
    input wire logic dac_to_speaker_path,
    input wire logic mono_to_speaker_path,
    input wire logic speaker_powersave_release,
    // clock presence from the pins
    input wire logic master_clock_input,
    input wire logic frame_clock_pin,
    input wire logic bit_clock_pin,
    // sample stream
    input wire logic [15:0] left_sample,
    input wire logic [15:0] right_sample,
    output logic [15:0] dac_left,
    output logic [15:0] dac_right,
    // status and drive enables
    output logic pll_locked,
    output logic clocks_out_enable,
    output logic mclk_out_valid,
    output logic normal_run,
    output logic dac_init_busy,
    output logic alc_active,
    output logic [7:0] alc_gain_left,
    output logic [7:0] alc_gain_right,
    output logic [7:0] vol_left,
    output logic [7:0] vol_right,
    output logic speaker_on
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_s1, pin_s2, pin_s3, next_s1, next_s2, next_s3, seen, present, next_present;
    logic frame_edge;
    always_comb begin
        next_s1 = {master_clock_input, frame_clock_pin, bit_clock_pin};
        next_s2 = pin_s1;
        next_s3 = pin_s2;
        seen = pin_s2 ^ pin_s3;
        frame_edge = pin_s2[1] & ~pin_s3[1];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {pin_s1, pin_s2, pin_s3} <= 9'h000;
        end else begin
            {pin_s1, pin_s2, pin_s3} <= {next_s1, next_s2, next_s3};
        end
    end
    // a clock counts as present once it has toggled since power-down
    always_comb begin
        next_present = ref_voltage_power ? (present | seen) : 3'h0;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) present <= 3'h0;
        else present <= next_present;
    end
    ////////////////////////////////////////////////////////////////////////
    // clock set-up state machine
    clk_state_t state, next_state;
    logic [CNT_W-1:0] lock_cnt, next_lock_cnt, lock_limit;
    logic ref_ok;
    always_comb begin
        case (pll_ref_sel)
            REF_FRAME: begin lock_limit = CNT_W'(LOCK_FRAME); ref_ok = present[1]; end
            REF_BIT: begin lock_limit = CNT_W'(LOCK_BIT); ref_ok = present[0]; end
            default: begin lock_limit = CNT_W'(LOCK_MCLK); ref_ok = present[2]; end
        endcase
        next_state = state;
        next_lock_cnt = lock_cnt;
        case (state)
            ST_IDLE: begin
                next_lock_cnt = '0;
                if (ref_voltage_power && pll_power) next_state = ST_LOCK;
                else if (ref_voltage_power) next_state = ST_EXT;
            end
            ST_LOCK: begin
                if (ref_ok) next_lock_cnt = lock_cnt + 1'b1;
                if (!pll_power || !ref_voltage_power) next_state = ST_IDLE;
                else if (lock_cnt >= lock_limit - 1'b1) next_state = ST_RUN;
            end
            ST_RUN: if (!pll_power || !ref_voltage_power) next_state = ST_IDLE;
            ST_EXT: if (pll_power || !ref_voltage_power) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            lock_cnt <= '0;
        end else begin
            state <= next_state;
            lock_cnt <= next_lock_cnt;
        end
    end
    logic next_locked, next_clk_oe, next_mclk_valid, next_run;
    always_comb begin
        next_locked = (next_state == ST_RUN);
        next_mclk_valid = master_clock_out_enable && next_locked;
        next_clk_oe = master_sel && (next_locked || (next_state == ST_EXT && present[2]));
        next_run = next_locked || (next_state == ST_EXT && (master_sel ? present[2]
                                                              : &present));
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {pll_locked, mclk_out_valid, clocks_out_enable, normal_run} <= 4'h0;
        end else begin
            {pll_locked, mclk_out_valid, clocks_out_enable, normal_run} <=
                {next_locked, next_mclk_valid, next_clk_oe, next_run};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // dac init cycle counted in frames
    logic dac_d, next_dac_d, next_busy;
    logic [FRM_W-1:0] frames, next_frames;
    always_comb begin
        next_dac_d = dac_power;
        next_frames = frames;
        next_busy = dac_init_busy;
        if (!dac_power) begin
            next_busy = 1'b0;
        end else if (!dac_d) begin
            next_busy = 1'b1;
            next_frames = '0;
        end else if (dac_init_busy && frame_edge) begin
            next_frames = frames + 1'b1;
            if (frames == FRM_W'(INIT_FRAMES - 1)) next_busy = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_d <= 1'b0;
            frames <= '0;
            dac_init_busy <= 1'b0;
        end else begin
            dac_d <= next_dac_d;
            frames <= next_frames;
            dac_init_busy <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data path, alc hold-off, volume ramp
    logic [15:0] next_dl, next_dr;
    logic next_alc, next_spk;
    logic [7:0] next_gl, next_gr, tgt_l, tgt_r, next_vl, next_vr;
    always_comb begin
        // samples are passed as two's complement untouched after init
        next_dl = (dac_init_busy || !dac_power) ? SAMPLE_ZERO : left_sample;
        next_dr = (dac_init_busy || !dac_power) ? SAMPLE_ZERO : right_sample;
        next_alc = alc_enable && dac_power && !dac_init_busy;
        next_gl = next_alc ? alc_gain_left : alc_left_volume;
        next_gr = next_alc ? alc_gain_right : alc_right_volume;
        tgt_l = out_left_volume;
        tgt_r = volume_couple ? out_left_volume : out_right_volume;
        // one step per frame; ramp restarts from 0 dB while dac is off
        next_vl = vol_left;
        next_vr = vol_right;
        if (!dac_power) begin
            next_vl = VOL_0DB;
            next_vr = VOL_0DB;
        end else if (frame_edge) begin
            if (vol_left < tgt_l) next_vl = vol_left + 1'b1;
            else if (vol_left > tgt_l) next_vl = vol_left - 1'b1;
            if (vol_right < tgt_r) next_vr = vol_right + 1'b1;
            else if (vol_right > tgt_r) next_vr = vol_right - 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_left <= SAMPLE_ZERO;
            dac_right <= SAMPLE_ZERO;
            alc_active <= 1'b0;
            alc_gain_left <= VOL_0DB;
            alc_gain_right <= VOL_0DB;
            vol_left <= VOL_0DB;
            vol_right <= VOL_0DB;
        end else begin
            dac_left <= next_dl;
            dac_right <= next_dr;
            alc_active <= next_alc;
            alc_gain_left <= next_gl;
            alc_gain_right <= next_gr;
            vol_left <= next_vl;
            vol_right <= next_vr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // speaker gating, no clock needed for the mono path
    always_comb begin
        next_spk = speaker_powersave_release && speaker_amp_power && ref_voltage_power
                   && ((dac_to_speaker_path && dac_power && mono_amp_power)
                       || (mono_to_speaker_path && mono_amp_power));
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) speaker_on <= 1'b0;
        else speaker_on <= next_spk;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_zero_init;
        @(posedge clk) disable iff (!rst_n)
            dac_init_busy |=> dac_left == SAMPLE_ZERO && dac_right == SAMPLE_ZERO;
    endproperty
    a_zero_init: assert property (p_zero_init)
        else $error("sample passed during init");
    property p_init_start;
        @(posedge clk) disable iff (!rst_n) $rose(dac_power) |=> ##1 dac_init_busy;
    endproperty
    a_init_start: assert property (p_init_start)
        else $error("init cycle did not start");
    property p_mclk_lock;
        @(posedge clk) disable iff (!rst_n) mclk_out_valid |-> pll_locked;
    endproperty
    a_mclk_lock: assert property (p_mclk_lock)
        else $error("mclk valid before lock");
    property p_oe_master;
        @(posedge clk) disable iff (!rst_n) clocks_out_enable |-> $past(master_sel);
    endproperty
    a_oe_master: assert property (p_oe_master)
        else $error("clocks driven without master select");
    property p_alc_hold;
        @(posedge clk) disable iff (!rst_n)
            dac_init_busy |=> !alc_active && alc_gain_left == $past(alc_left_volume);
    endproperty
    a_alc_hold: assert property (p_alc_hold)
        else $error("alc ran during init");
    property p_couple;
        @(posedge clk) disable iff (!rst_n)
            volume_couple && vol_left == vol_right |=> vol_left == vol_right;
    endproperty
    a_couple: assert property (p_couple)
        else $error("coupled volumes diverged");
    property p_vol_reset;
        @(posedge clk) disable iff (!rst_n) !dac_power |=> vol_left == VOL_0DB;
    endproperty
    a_vol_reset: assert property (p_vol_reset)
        else $error("volume not at 0 dB default");
    property p_spk;
        @(posedge clk) disable iff (!rst_n) speaker_on |-> $past(speaker_powersave_release);
    endproperty
    a_spk: assert property (p_spk)
        else $error("speaker on without release");
    property p_run_ext;
        @(posedge clk) disable iff (!rst_n) normal_run && !pll_locked |-> present[2];
    endproperty
    a_run_ext: assert property (p_run_ext)
        else $error("run without master clock");
    c_lock: cover property (@(posedge clk) disable iff (!rst_n) $rose(pll_locked));
    c_init_done: cover property (@(posedge clk) disable iff (!rst_n) $fell(dac_init_busy));
    c_spk: cover property (@(posedge clk) disable iff (!rst_n) $rose(speaker_on));
endmodule // audio_dac_clock_power_sequencer

// ### host_clock_model.sv
// host side clock source: master clock with frame and bit clocks divided from it
`timescale 1ns/1ps
module host_clock_model (
    // clock enables from the bench
    input wire logic run_m,
    input wire logic run_f,
    input wire logic run_b,
    // audio clock pins toward the device
    output logic master_clock_input,
    output logic frame_clock_pin,
    output logic bit_clock_pin
);
    logic mclk_free = 1'b0;
    logic [1:0] div = 2'h0;

    always #10 mclk_free = ~mclk_free;
    always @(posedge mclk_free) div <= div + 2'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // pins stand low while stopped, so a stale level never looks like a running clock
    // frame and bit divided from the master clock to stay in step with it
    assign master_clock_input = run_m & mclk_free;
    assign bit_clock_pin = run_b & div[0];
    assign frame_clock_pin = run_f & div[1];
endmodule // host_clock_model

// ### seq_pkg.sv
// constants and types for the audio dac clock and power sequencer
package seq_pkg;
    localparam int CLK_MHZ = 200;
    localparam int LOCK_MCLK_MS = 40;
    localparam int LOCK_FRAME_MS = 160;
    localparam int LOCK_BIT_MS = 2;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int LOCK_MCLK_CYC = LOCK_MCLK_MS * CYC_PER_MS;
    localparam int LOCK_FRAME_CYC = LOCK_FRAME_MS * CYC_PER_MS;
    localparam int LOCK_BIT_CYC = LOCK_BIT_MS * CYC_PER_MS;
    localparam int INIT_FRAMES = 1059;
    localparam logic [7:0] VOL_0DB = 8'h91;
    localparam logic [3:0] REF_MCLK = 4'h0;
    localparam logic [3:0] REF_FRAME = 4'h1;
    localparam logic [3:0] REF_BIT = 4'h2;
    localparam logic [15:0] SAMPLE_ZERO = 16'h0000;
    localparam int CNT_W = 32;
    localparam int FRM_W = 11;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOCK = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_EXT  = 4'b1000
    } clk_state_t;
endpackage

// ### tb_top.sv
// self-checking bench for the audio dac clock and power sequencer
`timescale 1ns/1ps
module tb_top;
    import seq_pkg::*;
    localparam int LK_M = 40;
    localparam int LK_F = 160;
    localparam int LK_B = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ref_voltage_power, pll_power, master_sel, master_clock_out_enable, dac_power;
    logic alc_enable, volume_couple, mono_amp_power, speaker_amp_power;
    logic dac_to_speaker_path, mono_to_speaker_path, speaker_powersave_release;
    logic [3:0] pll_ref_sel;
    logic [7:0] alc_left_volume, alc_right_volume, out_left_volume, out_right_volume;
    logic [15:0] left_sample, right_sample, dac_left, dac_right;
    logic master_clock_input, frame_clock_pin, bit_clock_pin, run_m, run_f, run_b;
    logic pll_locked, clocks_out_enable, mclk_out_valid, normal_run, dac_init_busy;
    logic alc_active, speaker_on;
    logic [7:0] alc_gain_left, alc_gain_right, vol_left, vol_right;
    int err_total = 0;
    int total_checks = 0;
    int n;
    int lim[3] = '{LK_M, LK_F, LK_B};

    always #2.5 clk = ~clk;

    audio_dac_clock_power_sequencer #(.LOCK_MCLK(LK_M), .LOCK_FRAME(LK_F), .LOCK_BIT(LK_B)) DUT (
        .clk, .rst_n, .ref_voltage_power, .pll_power, .pll_ref_sel, .master_sel,
        .master_clock_out_enable, .dac_power, .alc_enable, .volume_couple, .alc_left_volume,
        .alc_right_volume, .out_left_volume, .out_right_volume, .mono_amp_power,
        .speaker_amp_power, .dac_to_speaker_path, .mono_to_speaker_path,
        .speaker_powersave_release, .master_clock_input, .frame_clock_pin, .bit_clock_pin,
        .left_sample, .right_sample, .dac_left, .dac_right, .pll_locked, .clocks_out_enable,
        .mclk_out_valid, .normal_run, .dac_init_busy, .alc_active, .alc_gain_left,
        .alc_gain_right, .vol_left, .vol_right, .speaker_on);

    host_clock_model partner (.run_m, .run_f, .run_b, .master_clock_input, .frame_clock_pin,
        .bit_clock_pin);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // inputs change a fixed 1 ns after the edge
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // which: 0 watches pll_locked, 1 watches dac_init_busy
    task automatic wait_for(input int which, input logic lvl, input int max_cyc);
        n = 0;
        while (((which == 0) ? pll_locked : dac_init_busy) !== lvl && n < max_cyc) begin
            step(1);
            n++;
        end
    endtask

    task automatic chk_reset;
        chk("pll_locked", 1'b0, pll_locked);
        chk("speaker_on", 1'b0, speaker_on);
        chk("dac_init_busy", 1'b0, dac_init_busy);
        chk("clocks_out_enable", 1'b0, clocks_out_enable);
        chk("vol_left", VOL_0DB, vol_left);
    endtask

    task automatic give_verdict;
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {ref_voltage_power, pll_power, master_sel, dac_power, alc_enable} = '0;
        {mono_amp_power, speaker_amp_power, dac_to_speaker_path, mono_to_speaker_path} = '0;
        {speaker_powersave_release, run_m, run_f, run_b} = '0;
        {volume_couple, master_clock_out_enable} = 2'h3;
        pll_ref_sel = REF_MCLK;
        {alc_left_volume, alc_right_volume} = {VOL_0DB, VOL_0DB};
        {out_left_volume, out_right_volume} = {8'h8d, 8'h20};
        {left_sample, right_sample} = {16'h7fff, 16'h8000};
        // 31 cycles keeps the reset pin low past its 150 ns minimum
        step(31);
        rst_n = 1'b1;
        step(2);
        chk_reset();
        {run_m, run_f, run_b} = 3'h7;
        step(100);
        // clocks alone start nothing while vref is off
        chk("pll_locked", 1'b0, pll_locked);
        chk("normal_run", 1'b0, normal_run);
        for (int k = 0; k < 3; k++) begin
            // mode bits change only with vref off, and vref comes before the pll
            {ref_voltage_power, pll_power} = 2'h0;
            master_sel = (k == 0);
            pll_ref_sel = 4'(k);
            step(3);
            ref_voltage_power = 1'b1;
            step(1);
            pll_power = 1'b1;
            step(lim[k] / 2);
            chk("pll_locked", 1'b0, pll_locked);
            chk("mclk_out_valid", 1'b0, mclk_out_valid);
            chk("clocks_out_enable", 1'b0, clocks_out_enable);
            wait_for(0, 1'b1, lim[k] + 40);
            chk("lock_time_ok", 1'b1, n <= lim[k] / 2 + 16);
            step(2);
            chk("mclk_out_valid", 1'b1, mclk_out_valid);
            chk("clocks_out_enable", k == 0, clocks_out_enable);
            chk("normal_run", 1'b1, normal_run);
        end
        // dac powered only once the pll is locked
        alc_enable = 1'b1;
        dac_power = 1'b1;
        step(3);
        chk("dac_init_busy", 1'b1, dac_init_busy);
        chk("dac_left", SAMPLE_ZERO, dac_left);
        chk("dac_right", SAMPLE_ZERO, dac_right);
        chk("alc_active", 1'b0, alc_active);
        chk("alc_gain_left", VOL_0DB, alc_gain_left);
        chk("alc_gain_right", VOL_0DB, alc_gain_right);
        wait_for(1, 1'b0, 20000);
        // 16 cycles per frame, slack for sync and frame phase
        chk("init_len_ok", 1'b1, n >= 1057 * 16 && n <= 1061 * 16);
        step(1);
        chk("dac_left", 16'h7fff, dac_left);
        chk("dac_right", 16'h8000, dac_right);
        chk("alc_active", 1'b1, alc_active);
        chk("alc_gain_right", VOL_0DB, alc_gain_right);
        chk("vol_right", 8'h8d, vol_right);
        volume_couple = 1'b0;
        step(2000);
        chk("vol_left", 8'h8d, vol_left);
        chk("vol_right", 8'h20, vol_right);
        // speaker gain step sits outside this block; path first, then amps
        dac_to_speaker_path = 1'b1;
        {mono_amp_power, speaker_amp_power} = 2'h3;
        step(3);
        chk("speaker_on", 1'b0, speaker_on);
        speaker_powersave_release = 1'b1;
        step(3);
        chk("speaker_on", 1'b1, speaker_on);
        speaker_powersave_release = 1'b0;
        step(3);
        chk("speaker_on", 1'b0, speaker_on);
        dac_to_speaker_path = 1'b0;
        step(1);
        {pll_power, dac_power, run_m, run_f, run_b} = '0;
        mono_to_speaker_path = 1'b1;
        step(2);
        speaker_powersave_release = 1'b1;
        step(5);
        chk("speaker_on", 1'b1, speaker_on);
        speaker_powersave_release = 1'b0;
        step(1);
        {mono_amp_power, speaker_amp_power, mono_to_speaker_path, ref_voltage_power} = '0;
        step(3);
        // fresh vref with no clocks: presence must be earned again
        {master_sel, ref_voltage_power} = 2'h1;
        step(40);
        chk("normal_run", 1'b0, normal_run);
        {run_m, run_f, run_b} = 3'h7;
        step(40);
        chk("normal_run", 1'b1, normal_run);
        chk("clocks_out_enable", 1'b0, clocks_out_enable);
        master_sel = 1'b1;
        step(3);
        chk("clocks_out_enable", 1'b1, clocks_out_enable);
        rst_n = 1'b0;
        step(31);
        chk_reset();
        give_verdict();
    end

    initial begin
        #300000;
        err_total++;
        give_verdict();
    end
endmodule // tb_top
